//--- core/sgp_cfg.svh
`ifndef SGP_CFG_SVH
`define SGP_CFG_SVH
// Register indices (printed offsets), byte address = 4 * index
`define SGP_IDX_STATUS    8'h03
`define SGP_IDX_PORT      8'h05
`define SGP_IDX_INTCTL    8'h0b
`define SGP_IDX_OPTION    8'h81
`define SGP_IDX_DIR       8'h85
`define SGP_IDX_CONFIG    8'h90
`define SGP_IDX_ANSEL     8'h91
`define SGP_IDX_IRQ_STAT  8'h92
`define SGP_IDX_IRQ_MASK  8'h93
// Reset values
`define SGP_RST_OPTION    8'hff
`define SGP_RST_DIR       8'h3f
`define SGP_RST_STATUS    8'h18
`define SGP_RST_ANSEL     8'h17
`define SGP_RST_CONFIG    8'h00
// Field positions
`define SGP_INTCTL_PCIE   3
`define SGP_INTCTL_PCIF   0
`define SGP_OPTION_PUEN_N 7
`define SGP_CFG_OSC_LSB   0
`define SGP_CFG_MASTER_CLEAR_INPUT      3
`define SGP_CFG_CLOCK_OUTPUT    4
// Pins sharing pull-up and change detect: bits 0,1,3
`define SGP_CHANGE_MASK   8'h0b
`define SGP_DIR_FORCE1    8'h08
`define SGP_DIR_FORCE0    8'hc0
`endif

//--- core/sgp_pkg.sv
package sgp_pkg;
  typedef enum logic [2:0] {
    SGP_OSC_LP,
    SGP_OSC_XT,
    SGP_OSC_HS,
    SGP_OSC_INTERNAL_RC_OSC_MODE,
    SGP_OSC_INTERNAL_RC_OSC_MODE_CLOCK_OUTPUT,
    SGP_OSC_EXTERNAL_RC_OSC_MODE,
    SGP_OSC_EXTERNAL_RC_OSC_MODE_CLOCK_OUTPUT,
    SGP_OSC_RSVD
  } sgp_osc_mode_t;
  typedef enum logic [1:0] {
    SGP_APB_IDLE,
    SGP_APB_SETUP,
    SGP_APB_ACCESS
  } sgp_apb_phase_t;
endpackage

//--- core/sgp_gpio_port.sv
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "sgp_cfg.svh"
module sgp_gpio_port (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  input  wire logic [7:0]   pin_in,
  output logic [7:0]        pin_out,
  output logic [7:0]        pin_oe,
  output logic [7:0]        pin_pullup,
  output logic              irq
);
  import sgp_pkg::*;

  logic [7:0]       sync1_q;
  logic [7:0]       sync2_q;
  logic [7:0]       latch_q;
  logic [7:0]       dir_q;
  logic [7:0]       option_q;
  logic [7:0]       status_q;
  logic [7:0]       intctl_q;
  logic [7:0]       config_q;
  logic [7:0]       ansel_q;
  logic [7:0]       snap_q;
  logic [7:0]       irq_stat_q;
  logic [7:0]       irq_mask_q;
  logic [7:0]       dir_eff;
  logic [7:0]       alt_mask;
  logic [7:0]       pin_view;
  logic [7:0]       chg_en;
  logic [7:0]       rd_byte;
  logic [9:0]       idx;
  logic             wr_en;
  logic             rd_en;
  logic             hit;
  logic             pin_change;
  logic             ext_osc;
  logic             rc_mode;
  logic             clock_output;
  logic             master_clear_input;
  sgp_osc_mode_t    osc;

  assign idx     = paddr[11:2];
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign osc     = sgp_osc_mode_t'(config_q[2:0]);
  assign master_clear_input    = config_q[`SGP_CFG_MASTER_CLEAR_INPUT];
  assign rc_mode = (osc == SGP_OSC_INTERNAL_RC_OSC_MODE) || (osc == SGP_OSC_INTERNAL_RC_OSC_MODE_CLOCK_OUTPUT) ||
                   (osc == SGP_OSC_EXTERNAL_RC_OSC_MODE) || (osc == SGP_OSC_EXTERNAL_RC_OSC_MODE_CLOCK_OUTPUT);
  assign ext_osc = !rc_mode;
  assign clock_output  = (osc == SGP_OSC_INTERNAL_RC_OSC_MODE_CLOCK_OUTPUT) || (osc == SGP_OSC_EXTERNAL_RC_OSC_MODE_CLOCK_OUTPUT);

  // Decode of mapped indices; bus addresses above the byte range miss
  always_comb begin
    hit = 1'b0;
    case (idx[7:0])
      `SGP_IDX_STATUS, `SGP_IDX_PORT, `SGP_IDX_INTCTL, `SGP_IDX_OPTION,
      `SGP_IDX_DIR, `SGP_IDX_CONFIG, `SGP_IDX_ANSEL, `SGP_IDX_IRQ_STAT,
      `SGP_IDX_IRQ_MASK: hit = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  // Pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Pins taken by oscillator, master clear or analog read zero
  always_comb begin
    alt_mask = ansel_q & 8'h17;
    if (ext_osc) alt_mask = alt_mask | 8'h30;
    else if (clock_output) alt_mask = alt_mask | 8'h10;
    if (master_clear_input) alt_mask = alt_mask | 8'h08;
  end
  assign pin_view = sync2_q & ~alt_mask;

  // Effective direction with fixed bits
  assign dir_eff = (dir_q | `SGP_DIR_FORCE1) & ~`SGP_DIR_FORCE0;

  // Drivers
  assign pin_out = latch_q;
  assign pin_oe  = ~dir_eff & ~alt_mask;
  assign pin_pullup = (option_q[`SGP_OPTION_PUEN_N] ? 8'h00 : `SGP_CHANGE_MASK) |
                      (master_clear_input ? 8'h08 : 8'h00);

  // Output latches hold until rewritten
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 8'h00;
    end else if (wr_en && hit && idx[7:0] == `SGP_IDX_PORT) begin
      latch_q <= pwdata[7:0];
    end
  end

  // Direction register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= `SGP_RST_DIR;
    end else begin
      if (wr_en && hit && idx[7:0] == `SGP_IDX_DIR) begin
        dir_q[3:0] <= pwdata[3:0];
        if (rc_mode) begin
          dir_q[5] <= pwdata[5];
          if (!clock_output) dir_q[4] <= pwdata[4];
        end
      end
      if (!rc_mode) dir_q[5:4] <= 2'b11;
      if (clock_output) dir_q[4] <= 1'b1;
      dir_q[7:6] <= 2'b00;
    end
  end

  // Option, status, config, analog select, mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_q   <= `SGP_RST_OPTION;
      status_q   <= `SGP_RST_STATUS;
      config_q   <= `SGP_RST_CONFIG;
      ansel_q    <= `SGP_RST_ANSEL;
      irq_mask_q <= 8'h00;
    end else if (wr_en && hit) begin
      case (idx[7:0])
        `SGP_IDX_OPTION:   option_q   <= pwdata[7:0];
        `SGP_IDX_STATUS:   status_q   <= pwdata[7:0];
        `SGP_IDX_CONFIG:   config_q   <= pwdata[7:0];
        `SGP_IDX_ANSEL:    ansel_q    <= pwdata[7:0] & 8'h17;
        `SGP_IDX_IRQ_MASK: irq_mask_q <= pwdata[7:0] & 8'h01;
        default:           option_q   <= option_q;
      endcase
    end
  end

  // Change detection against last read snapshot
  assign chg_en = `SGP_CHANGE_MASK & ~(master_clear_input ? 8'h08 : 8'h00);
  assign pin_change = intctl_q[`SGP_INTCTL_PCIE] &&
                      (((pin_view ^ snap_q) & chg_en) != 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_q <= 8'h00;
    end else if (rd_en && hit && idx[7:0] == `SGP_IDX_PORT) begin
      snap_q <= pin_view;
    end
  end

  // Interrupt control: flag sticky, set beats software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intctl_q <= 8'h00;
    end else begin
      if (wr_en && hit && idx[7:0] == `SGP_IDX_INTCTL) intctl_q <= pwdata[7:0];
      if (pin_change) intctl_q[`SGP_INTCTL_PCIF] <= 1'b1;
    end
  end

  // Interrupt status, write one to clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 8'h00;
    end else begin
      if (wr_en && hit && idx[7:0] == `SGP_IDX_IRQ_STAT && pwdata[0])
        irq_stat_q[0] <= 1'b0;
      if (pin_change) irq_stat_q[0] <= 1'b1;
    end
  end
  assign irq = (irq_stat_q & irq_mask_q) != 8'h00;

  always_comb begin
    case (idx[7:0])
      `SGP_IDX_STATUS:   rd_byte = status_q;
      `SGP_IDX_PORT:     rd_byte = pin_view;
      `SGP_IDX_INTCTL:   rd_byte = intctl_q;
      `SGP_IDX_OPTION:   rd_byte = option_q;
      `SGP_IDX_DIR:      rd_byte = dir_eff;
      `SGP_IDX_CONFIG:   rd_byte = config_q;
      `SGP_IDX_ANSEL:    rd_byte = ansel_q;
      `SGP_IDX_IRQ_STAT: rd_byte = irq_stat_q;
      `SGP_IDX_IRQ_MASK: rd_byte = irq_mask_q;
      default:           rd_byte = 8'h00;
    endcase
  end
  assign prdata = (rd_en && hit) ? {24'h000000, rd_byte} : 32'h00000000;

  // Checks
  dir_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> dir_eff == 8'h3f)
    else $error("direction not all inputs after reset");
  dir_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    dir_eff[3] && dir_eff[7:6] == 2'b00)
    else $error("fixed direction bits wrong");
  port_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hit && idx[7:0] == `SGP_IDX_PORT |-> prdata[7:0] == (sync2_q & ~alt_mask))
    else $error("port read not pin levels");
  alt_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    master_clear_input |-> !pin_view[3] && !pin_change_masked3())
    else $error("master clear pin not zero");
  pcie_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !intctl_q[3] && !intctl_q[0] && !(wr_en && idx[7:0] == `SGP_IDX_INTCTL)
    |=> !intctl_q[0])
    else $error("change flag set while disabled");
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    intctl_q[0] && !(wr_en && hit && idx[7:0] == `SGP_IDX_INTCTL) |=> intctl_q[0])
    else $error("change flag dropped");
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_change |=> intctl_q[0] && irq_stat_q[0])
    else $error("change not flagged");
  drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_oe[0] |-> !dir_eff[0] && pin_out[0] == latch_q[0])
    else $error("driver state wrong");
  rc_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rc_mode |=> dir_q[5:4] == 2'b11)
    else $error("oscillator pins not forced input");
  pullup_a: assert property (@(posedge pclk) disable iff (!presetn)
    !option_q[7] |-> pin_pullup[1:0] == 2'b11)
    else $error("pull-ups not on");
  snap_cv: cover property (@(posedge pclk) disable iff (!presetn)
    rd_en && idx[7:0] == `SGP_IDX_PORT);
  change_cv: cover property (@(posedge pclk) disable iff (!presetn) pin_change);
  irq_cv: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  master_clear_input_cv: cover property (@(posedge pclk) disable iff (!presetn)
    master_clear_input && rd_en && hit);
  clock_output_cv: cover property (@(posedge pclk) disable iff (!presetn)
    clock_output && wr_en && hit && idx[7:0] == `SGP_IDX_DIR);

  // Driver and pull-up shape
  oe_shape_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_oe == (~dir_eff & ~alt_mask))
    else $error("output enable not from direction");
  out_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_out == latch_q)
    else $error("output not latch value");
  oe_input3_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_oe[3])
    else $error("input only pin driven");
  dir_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    dir_q[7:6] == 2'b00)
    else $error("memory line direction not zero");
  oe_alt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_oe & alt_mask) == 8'h00)
    else $error("alternate pin driven");
  pullup_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    option_q[7] && !master_clear_input |-> pin_pullup == 8'h00)
    else $error("pull-ups on while disabled");
  pullup_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_pullup[7:4] == 4'h0 && !pin_pullup[2])
    else $error("pull-up on unshared pin");
  pullup_on3_a: assert property (@(posedge pclk) disable iff (!presetn)
    !option_q[7] |-> pin_pullup[3])
    else $error("pin three pull-up off");
  master_clear_input_pu_a: assert property (@(posedge pclk) disable iff (!presetn)
    master_clear_input |-> pin_pullup[3])
    else $error("master clear pull-up off");
  master_clear_input_chg_a: assert property (@(posedge pclk) disable iff (!presetn)
    master_clear_input |-> !chg_en[3])
    else $error("master clear pin watched");

  // Read view of the pins
  osc_view_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_osc |-> pin_view[5:4] == 2'b00 && pin_oe[5:4] == 2'b00)
    else $error("oscillator pins not taken");
  clk_view_a: assert property (@(posedge pclk) disable iff (!presetn)
    clock_output |-> !pin_view[4] && !pin_oe[4])
    else $error("clock output pin not taken");
  analog_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_view & ansel_q & 8'h17) == 8'h00)
    else $error("analog pin not zero");
  ansel_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ansel_q & 8'he8) == 8'h00)
    else $error("analog select stray bits");
  read_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hit && idx[7:0] == `SGP_IDX_DIR |-> prdata[7:0] == dir_eff)
    else $error("direction read wrong");
  read_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  read_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_en |-> prdata == 32'h00000000)
    else $error("read data outside access");
  read_intctl_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hit && idx[7:0] == `SGP_IDX_INTCTL |-> prdata[7:0] == intctl_q)
    else $error("control read wrong");

  // Bus answer
  ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready)
    else $error("ready low");
  err_miss_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !hit |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  err_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && hit |-> !pslverr)
    else $error("mapped access refused");

  // Latches, snapshot and direction updates
  latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && hit && idx[7:0] == `SGP_IDX_PORT) |=> $stable(latch_q))
    else $error("latch changed without write");
  latch_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit && idx[7:0] == `SGP_IDX_PORT |=> latch_q == $past(pwdata[7:0]))
    else $error("latch not loaded");
  snap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(rd_en && hit && idx[7:0] == `SGP_IDX_PORT) |=> $stable(snap_q))
    else $error("snapshot changed without read");
  snap_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hit && idx[7:0] == `SGP_IDX_PORT |=> snap_q == $past(pin_view))
    else $error("snapshot not taken");
  dir_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit && idx[7:0] == `SGP_IDX_DIR |=> dir_q[3:0] == $past(pwdata[3:0]))
    else $error("direction write lost");
  dir_keep54_a: assert property (@(posedge pclk) disable iff (!presetn)
    rc_mode && !clock_output && !(wr_en && hit && idx[7:0] == `SGP_IDX_DIR)
    |=> dir_q[5:4] == $past(dir_q[5:4]))
    else $error("direction bits moved");
  clk_dir4_a: assert property (@(posedge pclk) disable iff (!presetn)
    clock_output |=> dir_q[4])
    else $error("clock output direction writable");
  option_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit && idx[7:0] == `SGP_IDX_OPTION |=> option_q == $past(pwdata[7:0]))
    else $error("option write lost");

  // Change detection and interrupt
  change_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !intctl_q[3] |-> !pin_change)
    else $error("change seen while disabled");
  change_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((pin_view ^ snap_q) & 8'hf4) != 8'h00 && ((pin_view ^ snap_q) & chg_en) == 8'h00
    |-> !pin_change)
    else $error("change on unwatched pin");
  flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit && idx[7:0] == `SGP_IDX_INTCTL && !pwdata[0] && !pin_change
    |=> !intctl_q[0])
    else $error("change flag not cleared");
  stat_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_stat_q[0] && !(wr_en && hit && idx[7:0] == `SGP_IDX_IRQ_STAT && pwdata[0])
    |=> irq_stat_q[0])
    else $error("status bit dropped");
  stat_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_stat_q[7:1] == 7'h00 && irq_mask_q[7:1] == 7'h00)
    else $error("status or mask stray bits");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (irq_stat_q[0] && irq_mask_q[0]))
    else $error("interrupt level wrong");

  function automatic logic pin_change_masked3();
    pin_change_masked3 = chg_en[3];
  endfunction
endmodule
`default_nettype wire

//--- verif/sgp_pin_partner.sv
`timescale 1ns/10ps
`default_nettype none
module sgp_pin_partner (
  input  wire logic       pclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      pin_in
);
  logic tog_q;
  initial tog_q = 1'b0;
  // Undriven lines without pull-up wander each cycle
  always_ff @(posedge pclk) begin
    tog_q <= ~tog_q;
  end
  // Outside drive overpowers the port driver in contention
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = tog_q;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_six_bit_gpio_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "sgp_cfg.svh"
module tb_six_bit_gpio_port;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val;
  int          err_count, compares;
  sgp_gpio_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .irq(irq));
  sgp_pin_partner ext_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    logic ok;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      ok = (pready === 1'b1);
      rd = prdata;
      serr = pslverr;
      @(posedge pclk);
    end while (!ok && n < 20);
    if (!ok) begin
      err_count++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic rchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(name, {24'h0, exp}, rd);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ext_en, ext_val} = '0;
    err_count = 0;
    compares = 0;
    idle(12);
    presetn <= 1'b1;
    chk("oe", 32'h0, {26'h0, pin_oe[5:0]});
    chk("oe_mem", 32'h3, {30'h0, pin_oe[7:6]});
    rchk("dir", `SGP_IDX_DIR, 8'h3f);
    rchk("option", `SGP_IDX_OPTION, 8'hff);
    chk("pullup", 32'h0, {24'h0, pin_pullup});
    apb(1'b1, `SGP_IDX_DIR, 8'h00);
    rchk("dir_lp", `SGP_IDX_DIR, 8'h38);
    apb(1'b1, `SGP_IDX_CONFIG, 8'h03);
    apb(1'b1, `SGP_IDX_DIR, 8'h00);
    rchk("dir_rc", `SGP_IDX_DIR, 8'h08);
    chk("oe", 32'h20, {26'h0, pin_oe[5:0]});
    $display("test direction done");
    ext_en <= 8'h08;
    ext_val <= 8'h08;
    apb(1'b1, `SGP_IDX_PORT, 8'h25);
    chk("latch", 32'h25, {26'h0, pin_out[5:0]});
    idle(3);
    apb(1'b0, `SGP_IDX_PORT, 8'h00);
    chk("analog", 32'h28, {26'h0, rd[5:0]});
    apb(1'b1, `SGP_IDX_ANSEL, 8'h00);
    idle(3);
    apb(1'b0, `SGP_IDX_PORT, 8'h00);
    chk("pins", 32'h2d, {26'h0, rd[5:0]});
    ext_en <= 8'h09;
    idle(3);
    apb(1'b0, `SGP_IDX_PORT, 8'h00);
    chk("contend", 32'h2c, {26'h0, rd[5:0]});
    apb(1'b1, `SGP_IDX_PORT, rd[7:0] | 8'h02);
    chk("rmw", 32'h2e, {26'h0, pin_out[5:0]});
    $display("test port data done");
    apb(1'b1, `SGP_IDX_CONFIG, 8'h04);
    apb(1'b1, `SGP_IDX_DIR, 8'h00);
    rchk("dir_clk", `SGP_IDX_DIR, 8'h18);
    apb(1'b1, `SGP_IDX_CONFIG, 8'h00);
    idle(3);
    apb(1'b0, `SGP_IDX_PORT, 8'h00);
    chk("osc", 32'h0e, {26'h0, rd[5:0]});
    ext_en <= 8'h39;
    ext_val <= 8'h28;
    apb(1'b1, `SGP_IDX_CONFIG, 8'h0b);
    idle(3);
    apb(1'b0, `SGP_IDX_PORT, 8'h00);
    chk("master_clear_input", 32'h26, {26'h0, rd[5:0]});
    chk("master_clear_input_pu", 32'h08, {24'h0, pin_pullup});
    apb(1'b1, `SGP_IDX_OPTION, 8'h7f);
    apb(1'b1, `SGP_IDX_CONFIG, 8'h03);
    chk("pullups", 32'h0b, {24'h0, pin_pullup});
    $display("test modes done");
    apb(1'b1, `SGP_IDX_IRQ_MASK, 8'h01);
    apb(1'b1, `SGP_IDX_INTCTL, 8'h00);
    idle(3);
    apb(1'b0, `SGP_IDX_PORT, 8'h00);
    ext_val <= 8'h00;
    idle(4);
    rchk("noen", `SGP_IDX_INTCTL, 8'h00);
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1'b1, `SGP_IDX_INTCTL, 8'h08);
    idle(2);
    rchk("flag", `SGP_IDX_INTCTL, 8'h09);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b0, `SGP_IDX_PORT, 8'h00);
    apb(1'b1, `SGP_IDX_INTCTL, 8'h08);
    apb(1'b1, `SGP_IDX_IRQ_STAT, 8'h01);
    rchk("flag_clr", `SGP_IDX_INTCTL, 8'h08);
    chk("irq_clr", 32'h0, {31'h0, irq});
    apb(1'b1, `SGP_IDX_IRQ_MASK, 8'h00);
    ext_val <= 8'h08;
    idle(4);
    chk("irq_mask", 32'h0, {31'h0, irq});
    rchk("irq_stat", `SGP_IDX_IRQ_STAT, 8'h01);
    $display("test interrupt done");
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped", 32'h0, rd);
    chk("slverr", 32'h1, {31'h0, serr});
    $display("test unmapped done");
    close_out();
  end
endmodule
`default_nettype wire
